// ===== src/ddrpc_byte_merge.v
`timescale 1ns/1ps

// ==========================================================
// Merge write data into a stored word under byte masks
module ddrpc_byte_merge (
    input  wire [31:0] old_i,
    input  wire [31:0] new_i,
    input  wire [3:0]  mask_i,
    output wire [31:0] merged_o
);
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_lane
            // Masked byte keeps its old contents
            assign merged_o[8*g+7:8*g] = mask_i[g] ? old_i[8*g+7:8*g]
                                                  : new_i[8*g+7:8*g];
        end
    endgenerate
endmodule // ddrpc_byte_merge

// ===== src/ddrpc_defs.vh
`ifndef DDRPC_DEFS_VH
`define DDRPC_DEFS_VH

// ==========================================================
// Command codes {rank_sel_n, row_n, col_n, wr_n}
`define DDRPC_CMD_MRS      4'h0
`define DDRPC_CMD_REF      4'h1
`define DDRPC_CMD_PRE      4'h2
`define DDRPC_CMD_ACT      4'h3
`define DDRPC_CMD_WR       4'h4
`define DDRPC_CMD_RD       4'h5
`define DDRPC_CMD_ZQ       4'h6
`define DDRPC_CMD_NOP      4'h7

// ==========================================================
// Address field positions
`define DDRPC_PRE_SCOPE_BIT 10
`define DDRPC_CHOP_BIT      12
`define DDRPC_COL_MSB       9
`define DDRPC_ROW_MSB       14

// Termination select bits in extended mode register one
`define DDRPC_MR1_TERM_B0   2
`define DDRPC_MR1_TERM_B1   6
`define DDRPC_MR1_TERM_B2   9

// ==========================================================
// Burst lengths in strobe edges
`define DDRPC_BEATS_FULL    4'h8
`define DDRPC_BEATS_CHOP    4'h4

// ==========================================================
// Power states
`define DDRPC_PS_ACTIVE     2'h0
`define DDRPC_PS_PPD        2'h1
`define DDRPC_PS_APD        2'h2
`define DDRPC_PS_SREF       2'h3

// ==========================================================
// Register byte offsets
`define DDRPC_REG_CTRL      8'h00
`define DDRPC_REG_STATUS    8'h04
`define DDRPC_REG_LAST_CMD  8'h08
`define DDRPC_REG_LAST_ADDR 8'h0c
`define DDRPC_REG_MR0       8'h10
`define DDRPC_REG_MR1       8'h14
`define DDRPC_REG_MR2       8'h18
`define DDRPC_REG_MR3       8'h1c
`define DDRPC_REG_CMD_CNT   8'h20

// Reset value and response codes
`define DDRPC_CTRL_RESET    1'b1
`define DDRPC_RESP_OKAY     2'b00
`define DDRPC_RESP_SLVERR   2'b10

`endif

// ===== src/ddrpc_sync.v
`timescale 1ns/1ps

// ==========================================================
// Two-stage synchroniser for pin inputs
module ddrpc_sync #(
    parameter WIDTH = 70
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] async_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_o   <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule // ddrpc_sync

// ===== src/ddrpc_top.v
// Contract
// - Rank select is one bit of every command code.
// - Clock enable high runs clocks, buffers and drivers; low stops them.
// - Clock enable low: idle banks give precharge power-down or self-refresh, open rows active.
// - Self-refresh exit on rising clock enable needs no running clock.
// - Power-down keeps only clock, termination and clock enable buffers.
// - Self-refresh keeps only the clock enable buffer.
// - Row address with activate, column address with read and write select a location; here only column bits 2:0 pick one of 8 stored words.
// - Address bit 10 on read and write requests auto-precharge.
// - Precharge: bit 10 low one bank, high all banks.
// - Mode register load carries op-code on address, stored into chosen register.
// - Address bit 12 on read and write: high full burst, low chopped.
// - Bank select picks bank, or mode register during a load.
// - Termination control registered high enables termination on data lines.
// - Termination disabled in extended mode register one ignores termination control.
// - Device strobe edge-aligned on reads; controller strobe centred on writes.
// - Strobes always used as differential pairs.
// - Command decoded from row, column and write strobes with rank select.
// - Write bytes with mask sampled high are discarded.
// - Mask sampled on both strobe edges.
// - Data lines are bidirectional.
// - Commands with rank select high are ignored.
// - Inputs sampled at rising clock crossing; read data on both crossings.
//
// The AXI4-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ddrpc_defs.vh"

module ddrpc_top (
    input  wire        clk_i,
    input  wire        rst_i,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Memory pins
    input  wire        ck_i,
    input  wire        ck_n_i,
    input  wire        cke_i,
    input  wire        rank_sel_n_i,
    input  wire        row_strobe_n_i,
    input  wire        col_strobe_n_i,
    input  wire        wr_strobe_n_i,
    input  wire [14:0] addr_i,
    input  wire [2:0]  bank_select_i,
    input  wire        termination_control_i,
    input  wire [3:0]  byte_write_mask_i,
    input  wire [31:0] data_lines_i,
    output reg  [31:0] data_lines_o,
    output wire [31:0] data_lines_oe_o,
    input  wire [3:0]  data_strobe_true_i,
    output reg  [3:0]  data_strobe_true_o,
    output wire [3:0]  data_strobe_true_oe_o,
    input  wire [3:0]  data_strobe_comp_i,
    output wire [3:0]  data_strobe_comp_o,
    output wire [3:0]  data_strobe_comp_oe_o,
    output reg         termination_on_o
);
    // ==========================================================
    // Pin synchronisation
    wire [69:0] pins_s;
    ddrpc_sync #(.WIDTH(70)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({ck_i, ck_n_i, cke_i, rank_sel_n_i, row_strobe_n_i,
                   col_strobe_n_i, wr_strobe_n_i, addr_i, bank_select_i,
                   termination_control_i, byte_write_mask_i, data_lines_i,
                   data_strobe_true_i, data_strobe_comp_i}),
        .sync_o  (pins_s)
    );

    wire        ck_s    = pins_s[69];
    wire        ck_n_s  = pins_s[68];
    wire        cke_s   = pins_s[67];
    wire [3:0]  cmd_s   = pins_s[66:63];
    wire [14:0] addr_s  = pins_s[62:48];
    wire [2:0]  bank_s  = pins_s[47:45];
    wire        odt_s   = pins_s[44];
    wire [3:0]  mask_s  = pins_s[43:40];
    wire [31:0] dq_s    = pins_s[39:8];
    wire [3:0]  dqs_s   = pins_s[7:4];
    wire [3:0]  dqs_n_s = pins_s[3:0];

    // Command code from rank select and the three strobes
    function [3:0] ddrpc_code;
        input [3:0] pins;
        begin
            ddrpc_code = pins[3] ? `DDRPC_CMD_NOP : pins;
        end
    endfunction

    // Rtt_Nom nonzero means termination is enabled
    function ddrpc_term_en;
        input [14:0] mr;
        begin
            ddrpc_term_en = mr[`DDRPC_MR1_TERM_B0] | mr[`DDRPC_MR1_TERM_B1] |
                            mr[`DDRPC_MR1_TERM_B2];
        end
    endfunction

    // ==========================================================
    // State
    reg        ck_prev_reg;
    reg [3:0]  dqs_prev_reg;
    reg [1:0]  pstate_reg;
    reg [7:0]  bank_open_reg;
    reg [14:0] open_row_reg [0:7];
    reg [14:0] mode_reg [0:3];
    reg [31:0] store_reg [0:7];
    reg        rd_active_reg;
    reg        wr_active_reg;
    reg [3:0]  beat_reg;
    reg [3:0]  beats_reg;
    reg [2:0]  col_base_reg;
    reg [2:0]  burst_bank_reg;
    reg        burst_ap_reg;
    reg [3:0]  last_code_reg;
    reg [2:0]  last_bank_reg;
    reg        last_ap_reg;
    reg        last_chop_reg;
    reg        last_all_reg;
    reg [14:0] last_addr_reg;
    reg [31:0] cmd_cnt_reg;
    reg        decode_en_reg;

    // Rising crossing only when the pair disagrees
    wire ck_rise  = ck_s & ~ck_n_s & ~ck_prev_reg;
    wire ck_cross = ck_s ^ ck_prev_reg;
    wire active   = (pstate_reg == `DDRPC_PS_ACTIVE);
    wire cmd_take = active & ck_rise & cke_s & decode_en_reg;
    wire [3:0] code = ddrpc_code(cmd_s);

    // Buffer gating per power state
    wire cmd_buf_en = active;
    wire odt_buf_en = (pstate_reg != `DDRPC_PS_SREF);

    // Strobe edge on lane 0, valid only as a true differential pair
    wire dqs_edge = (dqs_s[0] ^ dqs_prev_reg[0]) & (dqs_s[0] ^ dqs_n_s[0]);
    wire [2:0] wr_idx = col_base_reg + beat_reg[2:0];
    wire [31:0] merged;
    ddrpc_byte_merge u_merge (
        .old_i    (store_reg[wr_idx]),
        .new_i    (dq_s),
        .mask_i   (mask_s),
        .merged_o (merged)
    );

    wire burst_last = (beat_reg + 4'h1 == beats_reg);

    // ==========================================================
    // Power state and command handling
    integer i;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ck_prev_reg    <= 1'b0;
            dqs_prev_reg   <= 4'h0;
            pstate_reg     <= `DDRPC_PS_ACTIVE;
            bank_open_reg  <= 8'h00;
            rd_active_reg  <= 1'b0;
            wr_active_reg  <= 1'b0;
            beat_reg       <= 4'h0;
            beats_reg      <= `DDRPC_BEATS_FULL;
            col_base_reg   <= 3'h0;
            burst_bank_reg <= 3'h0;
            burst_ap_reg   <= 1'b0;
            last_code_reg  <= `DDRPC_CMD_NOP;
            last_bank_reg  <= 3'h0;
            last_ap_reg    <= 1'b0;
            last_chop_reg  <= 1'b0;
            last_all_reg   <= 1'b0;
            last_addr_reg  <= 15'h0000;
            cmd_cnt_reg    <= 32'h0;
            data_lines_o   <= 32'h0;
            data_strobe_true_o <= 4'h0;
            termination_on_o   <= 1'b0;
            for (i = 0; i < 8; i = i + 1) begin
                open_row_reg[i] <= 15'h0000;
                store_reg[i]    <= 32'h0;
            end
            for (i = 0; i < 4; i = i + 1) begin
                mode_reg[i] <= 15'h0000;
            end
        end else begin
            ck_prev_reg  <= ck_s;
            dqs_prev_reg <= dqs_s;

            // Termination sampled at rising crossing, gated by the mode
            if (!odt_buf_en) begin
                termination_on_o <= 1'b0;
            end else if (ck_rise) begin
                termination_on_o <= odt_s & ddrpc_term_en(mode_reg[1]);
            end

            // Power transitions
            case (pstate_reg)
                `DDRPC_PS_ACTIVE: begin
                    if (ck_rise && !cke_s) begin
                        if (code == `DDRPC_CMD_REF && bank_open_reg == 8'h00) begin
                            pstate_reg <= `DDRPC_PS_SREF;
                        end else if (bank_open_reg == 8'h00) begin
                            pstate_reg <= `DDRPC_PS_PPD;
                        end else begin
                            pstate_reg <= `DDRPC_PS_APD;
                        end
                    end
                end
                `DDRPC_PS_PPD, `DDRPC_PS_APD: begin
                    // Power-down exit still needs the clock
                    if (ck_rise && cke_s) begin
                        pstate_reg <= `DDRPC_PS_ACTIVE;
                    end
                end
                `DDRPC_PS_SREF: begin
                    // Clock may be stopped, so the level alone ends it
                    if (cke_s) begin
                        pstate_reg <= `DDRPC_PS_ACTIVE;
                    end
                end
                default: pstate_reg <= `DDRPC_PS_ACTIVE;
            endcase

            // Command decode
            if (cmd_take && code != `DDRPC_CMD_NOP) begin
                last_code_reg <= code;
                last_bank_reg <= bank_s;
                last_addr_reg <= addr_s;
                last_ap_reg   <= 1'b0;
                last_chop_reg <= 1'b0;
                last_all_reg  <= 1'b0;
                cmd_cnt_reg   <= cmd_cnt_reg + 32'h1;
                case (code)
                    `DDRPC_CMD_ACT: begin
                        bank_open_reg[bank_s] <= 1'b1;
                        open_row_reg[bank_s]  <= addr_s;
                    end
                    `DDRPC_CMD_PRE: begin
                        last_all_reg <= addr_s[`DDRPC_PRE_SCOPE_BIT];
                        if (addr_s[`DDRPC_PRE_SCOPE_BIT]) begin
                            bank_open_reg <= 8'h00;
                        end else begin
                            bank_open_reg[bank_s] <= 1'b0;
                        end
                    end
                    `DDRPC_CMD_RD, `DDRPC_CMD_WR: begin
                        last_ap_reg    <= addr_s[`DDRPC_PRE_SCOPE_BIT];
                        last_chop_reg  <= ~addr_s[`DDRPC_CHOP_BIT];
                        burst_ap_reg   <= addr_s[`DDRPC_PRE_SCOPE_BIT];
                        burst_bank_reg <= bank_s;
                        col_base_reg   <= addr_s[2:0];
                        beat_reg       <= 4'h0;
                        beats_reg      <= addr_s[`DDRPC_CHOP_BIT] ?
                                          `DDRPC_BEATS_FULL : `DDRPC_BEATS_CHOP;
                        rd_active_reg  <= (code == `DDRPC_CMD_RD);
                        wr_active_reg  <= (code == `DDRPC_CMD_WR);
                    end
                    `DDRPC_CMD_MRS: begin
                        if (!bank_s[2]) begin
                            mode_reg[bank_s[1:0]] <= addr_s;
                        end
                    end
                    default: ;
                endcase
            end else if (rd_active_reg && active && ck_cross) begin
                // Read beat on every crossing, strobe toggles with data
                data_lines_o       <= store_reg[col_base_reg + beat_reg[2:0]];
                data_strobe_true_o <= {4{~beat_reg[0]}};
                beat_reg           <= beat_reg + 4'h1;
                if (burst_last) begin
                    rd_active_reg <= 1'b0;
                    if (burst_ap_reg) begin
                        bank_open_reg[burst_bank_reg] <= 1'b0;
                    end
                end
            end else if (wr_active_reg && active && dqs_edge) begin
                // Controller centres its strobe, so data is stable here
                store_reg[wr_idx] <= merged;
                beat_reg          <= beat_reg + 4'h1;
                if (burst_last) begin
                    wr_active_reg <= 1'b0;
                    if (burst_ap_reg) begin
                        bank_open_reg[burst_bank_reg] <= 1'b0;
                    end
                end
            end
            if (!rd_active_reg) begin
                data_strobe_true_o <= 4'h0;
            end
        end
    end

    // Drivers run only while reading with clocks enabled
    wire drive = rd_active_reg & active;
    assign data_lines_oe_o       = {32{drive}};
    assign data_strobe_true_oe_o = {4{drive}};
    assign data_strobe_comp_oe_o = {4{drive}};
    assign data_strobe_comp_o    = ~data_strobe_true_o;

    // ==========================================================
    // AXI4-Lite write channel
    reg       aw_held_reg;
    reg       w_held_reg;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0]  w_strb_reg;

    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;

    always @(posedge clk_i) begin
        if (rst_i) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DDRPC_RESP_OKAY;
            decode_en_reg <= `DDRPC_CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_held_reg && w_held_reg) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg[7:2] == `DDRPC_REG_CTRL >> 2) begin
                    s_axi_bresp <= `DDRPC_RESP_OKAY;
                    if (w_strb_reg[0]) begin
                        decode_en_reg <= w_data_reg[0];
                    end
                end else begin
                    s_axi_bresp <= `DDRPC_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read channel
    assign s_axi_arready = ~s_axi_rvalid;

    always @(posedge clk_i) begin
        if (rst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `DDRPC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `DDRPC_RESP_OKAY;
            case ({s_axi_araddr[7:2], 2'b00})
                `DDRPC_REG_CTRL:      s_axi_rdata <= {31'h0, decode_en_reg};
                `DDRPC_REG_STATUS:    s_axi_rdata <= {16'h0, bank_open_reg, 1'b0,
                                                      odt_buf_en, cmd_buf_en,
                                                      wr_active_reg, rd_active_reg,
                                                      termination_on_o, pstate_reg};
                `DDRPC_REG_LAST_CMD:  s_axi_rdata <= {22'h0, last_all_reg, last_chop_reg,
                                                      last_ap_reg, last_bank_reg,
                                                      last_code_reg};
                `DDRPC_REG_LAST_ADDR: s_axi_rdata <= {17'h0, last_addr_reg};
                `DDRPC_REG_MR0:       s_axi_rdata <= {17'h0, mode_reg[0]};
                `DDRPC_REG_MR1:       s_axi_rdata <= {17'h0, mode_reg[1]};
                `DDRPC_REG_MR2:       s_axi_rdata <= {17'h0, mode_reg[2]};
                `DDRPC_REG_MR3:       s_axi_rdata <= {17'h0, mode_reg[3]};
                `DDRPC_REG_CMD_CNT:   s_axi_rdata <= cmd_cnt_reg;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `DDRPC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // ddrpc_top

// ===== verif/ddrpc_assertions.sv
`timescale 1ns/1ps
// ====================
// Bus and pin checker
module ddrpc_assertions (
    input logic        clk_i,
    input logic        rst_i,
    input logic        s_axi_awready,
    input logic        s_axi_arready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        termination_control_i,
    input logic        termination_on_o,
    input logic [31:0] data_lines_oe_o,
    input logic [3:0]  data_strobe_true_o,
    input logic [3:0]  data_strobe_true_oe_o,
    input logic [3:0]  data_strobe_comp_o,
    input logic [3:0]  data_strobe_comp_oe_o
);
    // One domain; reset masks all checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_strobe_pair: assert property (data_strobe_true_oe_o[0] |->
        data_strobe_comp_o == ~data_strobe_true_o) else $error("strobe pair not inverse");
    a_pair_enable: assert property (data_strobe_comp_oe_o == data_strobe_true_oe_o)
        else $error("strobe enables differ");
    a_dq_with_strobe: assert property (data_lines_oe_o[0] == data_strobe_true_oe_o[0])
        else $error("data and strobe enables differ");
    a_term_cause: assert property ($rose(termination_on_o) |->
        $past(termination_control_i, 3)) else $error("termination without request");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken during answer");
    a_ar_refused: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read accept wrong");
endmodule // ddrpc_assertions

bind ddrpc_top ddrpc_assertions u_ddrpc_assertions (.*);

// ===== verif/ddrpc_ctrl_model.sv
`timescale 1ns/1ps
// ====================
// Controller stand-in on the pin side
module ddrpc_ctrl_model (
    input  logic        clk_i,
    output logic        ck_o = 1'b0,
    output logic        ck_n_o = 1'b1,
    output logic        cke_o = 1'b1,
    output logic [3:0]  cmd_o = 4'hf,
    output logic [14:0] addr_o = 15'h0,
    output logic [2:0]  bank_o = 3'h0,
    output logic        odt_o = 1'b0,
    output logic [3:0]  mask_o = 4'h0,
    output logic [31:0] dq_o = 32'h5a5a_c3c3
);
    // One command per frame; clock parked outside frames
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
                       input logic k = 1'b1, input logic t = 1'b0);
        cmd_o <= c;
        bank_o <= b;
        addr_o <= a;
        cke_o <= k;
        odt_o <= t;
        repeat (5) @(posedge clk_i);
        ck_o <= 1'b1;
        ck_n_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        ck_o <= 1'b0;
        ck_n_o <= 1'b1;
        cmd_o <= 4'hf;
        addr_o <= ~a;
        mask_o <= ~mask_o;
        dq_o <= ~dq_o;
    endtask
    // Self-refresh exit with no clock running
    task automatic wake();
        cke_o <= 1'b1;
        repeat (8) @(posedge clk_i);
    endtask
endmodule // ddrpc_ctrl_model

// ===== verif/ddrpc_top_test.sv
`timescale 1ns/1ps
// ====================
// Self-checking bench
module ddrpc_top_test;
    logic        clk_i = 1'b0, rst_i = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata, dq_o, dq_oe, dq_m;
    wire  [3:0]  st_o, st_oe, sc_o, sc_oe, cmd, mask;
    wire  [14:0] addr;
    wire  [2:0]  bank;
    wire         ck, ck_n, cke, termination_control, term;
    logic [73:0] notes[$];
    int          n_mismatch = 0, cmp_count = 0;
    integer      seed = 32'he3b43a22;
    logic [14:0] op;
    // Shared pins resolved from enables
    ddrpc_ctrl_model u_ddrpc_ctrl_model (.clk_i, .ck_o(ck), .ck_n_o(ck_n), .cke_o(cke),
        .cmd_o(cmd), .addr_o(addr), .bank_o(bank), .odt_o(termination_control), .mask_o(mask), .dq_o(dq_m));
    ddrpc_top u_ddrpc_top (.*, .ck_i(ck), .ck_n_i(ck_n), .cke_i(cke), .rank_sel_n_i(cmd[3]),
        .row_strobe_n_i(cmd[2]), .col_strobe_n_i(cmd[1]), .wr_strobe_n_i(cmd[0]),
        .addr_i(addr), .bank_select_i(bank), .termination_control_i(termination_control),
        .byte_write_mask_i(mask), .data_lines_i((dq_oe & dq_o) | (~dq_oe & dq_m)),
        .data_lines_o(dq_o), .data_lines_oe_o(dq_oe), .data_strobe_true_i(st_oe & st_o),
        .data_strobe_true_o(st_o), .data_strobe_true_oe_o(st_oe),
        .data_strobe_comp_i(~sc_oe | sc_o), .data_strobe_comp_o(sc_o),
        .data_strobe_comp_oe_o(sc_oe), .termination_on_o(term));
    // 125 MHz clock
    initial forever #4 clk_i = ~clk_i;
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Note layout: address, expected, mask, response
    task automatic check(input logic [73:0] n, input logic [31:0] d, input logic [1:0] r);
        cmp_count++;
        if (((d & n[33:2]) !== n[65:34]) || (r !== n[1:0])) begin
            n_mismatch++;
            $display("CHECK FAILED reg %h expected %h/%h seen %h/%h",
                     n[73:66], n[65:34], n[1:0], d & n[33:2], r);
        end
    endtask
    // Answers compared against the oldest note
    always @(posedge clk_i) begin
        if ((s_axi_rvalid & s_axi_rready) === 1'b1) check(notes.pop_front(), s_axi_rdata, s_axi_rresp);
        else if ((s_axi_bvalid & s_axi_bready) === 1'b1) check(notes.pop_front(), 0, s_axi_bresp);
    end
    // Ready raised at random, then held until the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        bit done;
        notes.push_back({a, 64'h0, r});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            done = (s_axi_bvalid & s_axi_bready) === 1'b1;
            s_axi_bready <= done ? 1'b0 : (s_axi_bready | 1'($random(seed)));
        end while (!done);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r = 2'b00);
        bit done;
        notes.push_back({a, e, m, r});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            done = (s_axi_rvalid & s_axi_rready) === 1'b1;
            s_axi_rready <= done ? 1'b0 : (s_axi_rready | 1'($random(seed)));
        end while (!done);
    endtask
    task automatic pc(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
                      input logic k = 1'b1, input logic t = 1'b0);
        u_ddrpc_ctrl_model.cmd(c, b, a, k, t);
    endtask
    task automatic nop(input logic k = 1'b1);
        pc(4'h7, 3'h0, 15'h0, k, 1'b1);
    endtask
    // Hang guard, well past the expected run
    initial begin
        #60us;
        n_mismatch++;
        report_and_stop();
    end
    // ====================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(8'h00, 32'h1, 32'h1);
        rd(8'h24, 32'h0, 32'hffff_ffff, 2'b10);
        wr(8'h04, 32'h0, 2'b10);
        wr(8'h00, 32'h1, 2'b00);
        $display("registers done");
        for (int b = 0; b < 4; b++) begin
            op = 15'($random(seed));
            pc(4'h0, b[2:0], op);
            rd(8'h10 + 8'(b * 4), {17'h0, op}, 32'h7fff);
        end
        pc(4'h3, 3'h5, op);
        rd(8'h0c, {17'h0, op}, 32'h7fff);
        rd(8'h04, 32'h2000, 32'hff03);
        pc(4'h5, 3'h5, 15'h0403);
        rd(8'h08, 32'h1d5, 32'h1ff);
        nop();
        nop();
        pc(4'h9, 3'h5, 15'h0);
        rd(8'h08, 32'h1d5, 32'h1ff);
        rd(8'h04, 32'h0, 32'hff03);
        pc(4'h4, 3'h2, 15'h1000);
        rd(8'h08, 32'h024, 32'h1ff);
        pc(4'h3, 3'h1, op);
        pc(4'h3, 3'h3, op);
        pc(4'h2, 3'h1, 15'h0);
        rd(8'h04, 32'h0800, 32'hff03);
        pc(4'h2, 3'h0, 15'h0400);
        rd(8'h08, 32'h202, 32'h27f);
        rd(8'h04, 32'h0, 32'hff03);
        rd(8'h20, 32'd11, 32'hffff_ffff);
        $display("commands done");
        pc(4'h0, 3'h1, 15'h0004, 1'b1, 1'b1);
        nop();
        rd(8'h04, 32'h4, 32'hff07);
        nop(1'b0);
        pc(4'h3, 3'h0, 15'h0, 1'b0, 1'b1);
        rd(8'h04, 32'h5, 32'hff07);
        nop();
        pc(4'h3, 3'h0, 15'h0, 1'b1, 1'b1);
        nop(1'b0);
        rd(8'h04, 32'h106, 32'hff07);
        nop();
        pc(4'h2, 3'h0, 15'h0400, 1'b1, 1'b1);
        pc(4'h1, 3'h0, 15'h0, 1'b0, 1'b1);
        rd(8'h04, 32'h3, 32'hff07);
        u_ddrpc_ctrl_model.wake();
        rd(8'h04, 32'h0, 32'h3);
        pc(4'h0, 3'h1, 15'h0, 1'b1, 1'b1);
        nop();
        rd(8'h04, 32'h0, 32'h4);
        $display("power and termination done");
        @(posedge clk_i);
        report_and_stop();
    end
endmodule // ddrpc_top_test
